//--- src/atc_timer_async.sv
// Purpose: Clock-domain control of an 8-bit timer that may run from a slow oscillator pin.
// Assumes: CLK well above four times the oscillator; oscillator pin sampled on CLK.
// Notes: Waveform modes are a plain subset; compare outputs simply toggle on a match.
// Behaviour
// - Writes go to a holding register, moved after the second rising oscillator edge.
// - Five registers each own a holding register; transfers never disturb each other.
// - Compare match is suppressed while a compare or counter write is pending.
// - Wake logic rearms after one oscillator cycle; earlier sleep gives no wake.
// - Wake-up starts on the timer clock cycle after the interrupt condition.
// - Counter reads use a copy refreshed on each rising oscillator edge outside sleep.
// - Asynchronous flags reach the processor after three cycles plus one timer cycle.
// - Compare outputs change on the timer clock, not resynchronised.
// - Oscillator runs with async select, except in deep power-down or with an external clock; timer registers keep their values in deep power-down.
// - Mask holds compare B, compare A and overflow enables; all three terms needed.
// - Flags set on compare B, compare A and overflow; upper bits read zero.
// - Flags clear on vector execution or on writing one; zero leaves them.
// - In phase-correct modes overflow sets on the direction change at bottom.
// - Source defaults to CLK; async select uses the pin and releases the port.
// - Prescaler offers stop, undivided and divide by 8 to 1024.
// - Prescaler reset bit self-clears, waits in async mode, holds while hold bit set.
// - Busy flags set on asynchronous writes and clear after the transfer.
// - Counter reads return the count; compare and control reads return their holding registers.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module atc_timer_async
   import atc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic ASYNC_CLOCK_PIN_IN,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic [2:0] VECTOR_DONE,
   input wire logic SLEEP_ACTIVE,
   input wire logic DEEP_SLEEP,
   output logic [2:0] IRQ_REQ,
   output logic WAKE_REQ,
   output logic COMPARE_A_OUT,
   output logic COMPARE_B_OUT,
   output logic OSC_RUN,
   output logic PORT_RELEASE
);
   logic [7:0] hold_ff [ATC_NHOLD];
   logic [ATC_NHOLD-1:0] pend_ff;
   logic [7:0] dest_ff [1:4];
   logic [7:0] count_ff, nxt_count;
   logic [7:0] count_rd_ff;
   logic up_ff, nxt_up;
   logic as_ff, extclk_ff;
   logic [2:0] mask_ff, flag_ff, nxt_flag;
   logic hold_mode_ff, prst_ff, nxt_prst;
   logic [9:0] presc_ff;
   logic sync1_ff, sync2_ff, sync3_ff;
   logic [2:0] ev_pipe_ff [ATC_FLAG_SYNC];
   logic wake_pend_ff, armed_ff;
   logic [7:0] rdata_nxt;

   // Oscillator pin: the first flop feeds only the second.
   // The third flop only marks the edge and adds no cycle; the tick follows the second flop.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= ASYNC_CLOCK_PIN_IN;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // Deep sleep stops the oscillator, so no timer edge can be seen while it is set.
   wire osc_on = as_ff & ~DEEP_SLEEP;
   wire aedge = osc_on & sync2_ff & ~sync3_ff;
   wire src_tick = as_ff ? aedge : 1'b1;

   // Register port decode.
   // Writes outside the map decode to nothing and are dropped.
   wire wr_count = REG_WR & (REG_ADDR == ATC_OFS_COUNT);
   wire wr_astat = REG_WR & (REG_ADDR == ATC_OFS_ASTAT);
   wire wr_mask = REG_WR & (REG_ADDR == ATC_OFS_MASK);
   wire wr_flags = REG_WR & (REG_ADDR == ATC_OFS_FLAGS);
   wire wr_gtc = REG_WR & (REG_ADDR == ATC_OFS_GTC);
   wire [ATC_NHOLD-1:0] wr_slot;
   assign wr_slot[ATC_H_COUNT] = wr_count;
   assign wr_slot[ATC_H_CMPA] = REG_WR & (REG_ADDR == ATC_OFS_CMPA);
   assign wr_slot[ATC_H_CMPB] = REG_WR & (REG_ADDR == ATC_OFS_CMPB);
   assign wr_slot[ATC_H_CTLA] = REG_WR & (REG_ADDR == ATC_OFS_CTLA);
   assign wr_slot[ATC_H_CTLB] = REG_WR & (REG_ADDR == ATC_OFS_CTLB);

   // Counter load path, driven from slot zero of the loop below.
   wire cnt_load;
   wire [7:0] cnt_load_val;

   // Each slot has its own edge count, so writes to other slots never touch it.
   // A rewrite while busy restarts the count; the value in flight is simply replaced.
   genvar gi;
   generate
      for (gi = 0; gi < ATC_NHOLD; gi++) begin : g_hold
         logic [1:0] edges_ff;
         wire done = pend_ff[gi] & aedge & (edges_ff == ATC_XFER_EDGES - 2'h1);
         always_ff @(posedge CLK) begin
            if (!RST_N) begin
               hold_ff[gi] <= ATC_RST_BYTE;
               pend_ff[gi] <= 1'b0;
               edges_ff <= 2'h0;
            end else if (wr_slot[gi]) begin
               hold_ff[gi] <= REG_WDATA;
               pend_ff[gi] <= as_ff;
               edges_ff <= 2'h0;
            end else if (done) begin
               pend_ff[gi] <= 1'b0;
               edges_ff <= 2'h0;
            end else if (pend_ff[gi] & aedge) begin
               edges_ff <= edges_ff + 2'h1;
            end
         end
         // In sync mode a write lands at once; in async mode it waits for the transfer.
         if (gi > 0) begin : g_dest
            always_ff @(posedge CLK) begin
               if (!RST_N) begin
                  dest_ff[gi] <= ATC_RST_BYTE;
               end else if ((wr_slot[gi] & ~as_ff) | done) begin
                  dest_ff[gi] <= wr_slot[gi] ? REG_WDATA : hold_ff[gi];
               end
            end
         end else begin : g_cnt
            assign cnt_load = (wr_slot[gi] & ~as_ff) | done;
            assign cnt_load_val = wr_slot[gi] ? REG_WDATA : hold_ff[gi];
         end
      end
   endgenerate

   // Prescaler with reset request.
   // Every dividing tap decodes one shared count, so all ratios restart together after a reset.
   wire [2:0] clk_sel = dest_ff[ATC_H_CTLB][2:0];
   wire tap_sel = (clk_sel == ATC_CS_DIV1) ? 1'b1 :
                  (clk_sel == ATC_CS_DIV8) ? (&presc_ff[2:0]) :
                  (clk_sel == ATC_CS_DIV32) ? (&presc_ff[4:0]) :
                  (clk_sel == ATC_CS_DIV64) ? (&presc_ff[5:0]) :
                  (clk_sel == ATC_CS_DIV128) ? (&presc_ff[6:0]) :
                  (clk_sel == ATC_CS_DIV256) ? (&presc_ff[7:0]) :
                  (clk_sel == ATC_CS_DIV1024) ? (&presc_ff[9:0]) : 1'b0;
   wire tick = src_tick & tap_sel & ~prst_ff & (clk_sel != ATC_CS_STOP);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         presc_ff <= ATC_RST_PRESC;
      end else if (prst_ff) begin
         presc_ff <= ATC_RST_PRESC;
      end else if (src_tick) begin
         presc_ff <= presc_ff + 10'h001;
      end
   end

   // The reset bit waits for an oscillator edge in async mode so the reset really lands.
   wire prst_release = prst_ff & ~hold_mode_ff & (~as_ff | aedge);
   always_comb begin
      nxt_prst = prst_ff;
      if (wr_gtc & REG_WDATA[ATC_G_PRST]) begin
         nxt_prst = 1'b1;
      end else if (prst_release) begin
         nxt_prst = 1'b0;
      end
   end

   // Counter core.
   // The counter moves on the processor clock, gated by the selected timer tick.
   wire [2:0] wave_mode = {dest_ff[ATC_H_CTLB][3], dest_ff[ATC_H_CTLA][1:0]};
   wire [7:0] top_val = wave_mode[2] ? dest_ff[ATC_H_CMPA] : ATC_MAX;
   wire phase_corr = (wave_mode[1:0] == 2'b01);
   wire ctc_mode = (wave_mode == 3'b010);
   wire at_top = ctc_mode ? (count_ff == dest_ff[ATC_H_CMPA]) : (count_ff == top_val);
   // A match is blocked while the count or its compare value is in flight, since the
   // pair seen by the comparator is not yet the one software wrote.
   wire cmp_ok_a = ~pend_ff[ATC_H_COUNT] & ~pend_ff[ATC_H_CMPA];
   wire cmp_ok_b = ~pend_ff[ATC_H_COUNT] & ~pend_ff[ATC_H_CMPB];
   wire ev_a = tick & cmp_ok_a & (count_ff == dest_ff[ATC_H_CMPA]);
   wire ev_b = tick & cmp_ok_b & (count_ff == dest_ff[ATC_H_CMPB]);
   wire ev_o = tick & (phase_corr ? (~up_ff & (count_ff == ATC_BOTTOM)) :
                                    (count_ff == ATC_MAX));
   wire [2:0] ev_now = {ev_b, ev_a, ev_o};

   // A load beats a tick, so a written count is never bumped in the same cycle.
   always_comb begin
      nxt_count = count_ff;
      nxt_up = up_ff;
      if (cnt_load) begin
         nxt_count = cnt_load_val;
      end else if (tick & phase_corr) begin
         if (up_ff & at_top) begin
            nxt_up = 1'b0;
            nxt_count = count_ff - 8'h01;
         end else if (~up_ff & (count_ff == ATC_BOTTOM)) begin
            nxt_up = 1'b1;
            nxt_count = count_ff + 8'h01;
         end else begin
            nxt_count = up_ff ? count_ff + 8'h01 : count_ff - 8'h01;
         end
      end else if (tick) begin
         nxt_up = 1'b1;
         nxt_count = at_top ? ATC_BOTTOM : count_ff + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count_ff <= ATC_RST_BYTE;
         up_ff <= 1'b1;
         count_rd_ff <= ATC_RST_BYTE;
      end else begin
         count_ff <= nxt_count;
         up_ff <= nxt_up;
         // The copy freezes in sleep, so the first read after wake shows the old count.
         if (aedge & ~SLEEP_ACTIVE) begin
            count_rd_ff <= count_ff;
         end
      end
   end

   // Flag path: three processor cycles behind the timer event in async mode.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int k = 0; k < ATC_FLAG_SYNC; k++) begin
            ev_pipe_ff[k] <= 3'h0;
         end
      end else begin
         ev_pipe_ff[0] <= ev_now;
         for (int k = 1; k < ATC_FLAG_SYNC; k++) begin
            ev_pipe_ff[k] <= ev_pipe_ff[k-1];
         end
      end
   end
   // In sync mode the flag follows the event at once; the pipe models the crossing only.
   wire [2:0] flag_set = as_ff ? ev_pipe_ff[ATC_FLAG_SYNC-1] : ev_now;
   wire [2:0] flag_clr = VECTOR_DONE | (wr_flags ? REG_WDATA[2:0] : 3'h0);

   // A set in the same cycle as a clear wins, so no event is dropped.
   assign nxt_flag = (flag_ff & ~flag_clr) | flag_set;

   // Wake control: the condition arms a start that fires on the next timer clock.
   // A start is dropped if the processor is already awake, so no request appears late.
   wire wake_cond = SLEEP_ACTIVE & armed_ff & (|(ev_now & mask_ff));
   wire wake_fire = wake_pend_ff & aedge & SLEEP_ACTIVE;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         wake_pend_ff <= 1'b0;
         WAKE_REQ <= 1'b0;
         armed_ff <= 1'b1;
      end else begin
         if (wake_pend_ff & aedge) begin
            wake_pend_ff <= 1'b0;
         end else if (wake_cond) begin
            wake_pend_ff <= 1'b1;
         end
         if (wake_fire) begin
            WAKE_REQ <= 1'b1;
            armed_ff <= 1'b0;
         end else if (~SLEEP_ACTIVE) begin
            WAKE_REQ <= 1'b0;
            if (aedge) begin
               armed_ff <= 1'b1;
            end
         end
      end
   end

   // Software registers and outputs.
   // Writing the status register switches the source at once; the slots are not flushed.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         as_ff <= 1'b0;
         extclk_ff <= 1'b0;
         mask_ff <= 3'h0;
         flag_ff <= 3'h0;
         hold_mode_ff <= 1'b0;
         prst_ff <= 1'b0;
         IRQ_REQ <= 3'h0;
         COMPARE_A_OUT <= 1'b0;
         COMPARE_B_OUT <= 1'b0;
         OSC_RUN <= 1'b0;
         PORT_RELEASE <= 1'b0;
      end else begin
         if (wr_astat) begin
            as_ff <= REG_WDATA[ATC_ST_ASYNC];
            extclk_ff <= REG_WDATA[ATC_ST_EXTCLK];
         end
         if (wr_mask) begin
            mask_ff <= REG_WDATA[2:0];
         end
         if (wr_gtc) begin
            hold_mode_ff <= REG_WDATA[ATC_G_HOLD];
         end
         flag_ff <= nxt_flag;
         prst_ff <= nxt_prst;
         // Requests are registered, so they trail the flag by one processor cycle.
         IRQ_REQ <= mask_ff & flag_ff & {3{GLOBAL_IRQ_EN}};
         COMPARE_A_OUT <= COMPARE_A_OUT ^ ev_a;
         COMPARE_B_OUT <= COMPARE_B_OUT ^ ev_b;
         // The crystal stage stays off while an external clock is fed in on the pin.
         OSC_RUN <= osc_on & ~extclk_ff;
         PORT_RELEASE <= as_ff;
      end
   end

   // Read mux; the counter is live in sync mode and the edge copy in async mode.
   // Busy bits come straight from the pending flags of the slots.
   wire [7:0] astat_rd = {1'b0, extclk_ff, as_ff, pend_ff[ATC_H_COUNT], pend_ff[ATC_H_CMPA],
                          pend_ff[ATC_H_CMPB], pend_ff[ATC_H_CTLA], pend_ff[ATC_H_CTLB]};
   always_comb begin
      unique case (REG_ADDR)
         ATC_OFS_COUNT: rdata_nxt = as_ff ? count_rd_ff : count_ff;
         ATC_OFS_CMPA: rdata_nxt = hold_ff[ATC_H_CMPA];
         ATC_OFS_CMPB: rdata_nxt = hold_ff[ATC_H_CMPB];
         ATC_OFS_CTLA: rdata_nxt = hold_ff[ATC_H_CTLA];
         ATC_OFS_CTLB: rdata_nxt = hold_ff[ATC_H_CTLB];
         ATC_OFS_ASTAT: rdata_nxt = astat_rd;
         ATC_OFS_MASK: rdata_nxt = {5'h00, mask_ff};
         ATC_OFS_FLAGS: rdata_nxt = {5'h00, flag_ff};
         ATC_OFS_GTC: rdata_nxt = {hold_mode_ff, 5'h00, prst_ff, 1'b0};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Read data stand for one cycle only and are zero otherwise.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= REG_RD ? rdata_nxt : 8'h00;
      end
   end
endmodule

//--- src/atc_pkg.sv
// Purpose: Shared constants for the asynchronous timer clock-domain controller.
// Assumes: Byte-wide register port, 4-bit register index.
// Notes: Offsets are register indices on the plain register port.
package atc_pkg;
   localparam int ATC_AW = 4;
   localparam int ATC_NHOLD = 5;
   // Register indices.
   localparam logic [3:0] ATC_OFS_COUNT = 4'h0;
   localparam logic [3:0] ATC_OFS_CMPA = 4'h1;
   localparam logic [3:0] ATC_OFS_CMPB = 4'h2;
   localparam logic [3:0] ATC_OFS_CTLA = 4'h3;
   localparam logic [3:0] ATC_OFS_CTLB = 4'h4;
   localparam logic [3:0] ATC_OFS_ASTAT = 4'h5;
   localparam logic [3:0] ATC_OFS_MASK = 4'h6;
   localparam logic [3:0] ATC_OFS_FLAGS = 4'h7;
   localparam logic [3:0] ATC_OFS_GTC = 4'h8;
   // Holding register slots; busy bit position is 4 minus the slot.
   localparam int ATC_H_COUNT = 0;
   localparam int ATC_H_CMPA = 1;
   localparam int ATC_H_CMPB = 2;
   localparam int ATC_H_CTLA = 3;
   localparam int ATC_H_CTLB = 4;
   // Status register fields.
   localparam int ATC_ST_EXTCLK = 6;
   localparam int ATC_ST_ASYNC = 5;
   // Flag and enable bits.
   localparam int ATC_B_CMPB = 2;
   localparam int ATC_B_CMPA = 1;
   localparam int ATC_B_OVF = 0;
   // General timer control fields.
   localparam int ATC_G_HOLD = 7;
   localparam int ATC_G_PRST = 1;
   // Reset values.
   localparam logic [7:0] ATC_RST_BYTE = 8'h00;
   localparam logic [9:0] ATC_RST_PRESC = 10'h000;
   // Transfer needs this many rising asynchronous edges.
   localparam logic [1:0] ATC_XFER_EDGES = 2'h2;
   // Flag synchroniser depth in processor cycles.
   localparam int ATC_FLAG_SYNC = 3;
   // Clock select codes.
   localparam logic [2:0] ATC_CS_STOP = 3'h0;
   localparam logic [2:0] ATC_CS_DIV1 = 3'h1;
   localparam logic [2:0] ATC_CS_DIV8 = 3'h2;
   localparam logic [2:0] ATC_CS_DIV32 = 3'h3;
   localparam logic [2:0] ATC_CS_DIV64 = 3'h4;
   localparam logic [2:0] ATC_CS_DIV128 = 3'h5;
   localparam logic [2:0] ATC_CS_DIV256 = 3'h6;
   localparam logic [2:0] ATC_CS_DIV1024 = 3'h7;
   localparam logic [7:0] ATC_MAX = 8'hFF;
   localparam logic [7:0] ATC_BOTTOM = 8'h00;
endpackage

//--- tb/atc_osc_model.sv
// Purpose: Behavioural watch oscillator that drives the asynchronous clock pin.
// Assumes: Period scaled to twenty processor cycles.
// Notes: The pin stands still while the oscillator is not running.
`timescale 1ns/1ps
module atc_osc_model #(
   parameter int HALF_NS = 1000
) (
   input wire logic RUN,
   output logic PIN
);
   // A period of twenty processor cycles stays well clear of the four-times limit.
   initial begin
      PIN = 1'b0;
      forever begin
         #(HALF_NS);
         if (RUN) begin
            PIN = ~PIN;
         end
      end
   end
endmodule

//--- tb/atc_timer_async_chk.sv
// Purpose: Port-level checks of the asynchronous timer controller.
// Assumes: Rising oscillator edges are at least twenty processor cycles apart.
// Notes: The edge-age bound leaves room for the pin synchroniser.
`timescale 1ns/1ps
module atc_timer_async_chk
   import atc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic ASYNC_CLOCK_PIN_IN,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic SLEEP_ACTIVE,
   input wire logic DEEP_SLEEP,
   input wire logic [2:0] IRQ_REQ,
   input wire logic WAKE_REQ,
   input wire logic COMPARE_A_OUT,
   input wire logic COMPARE_B_OUT,
   input wire logic OSC_RUN,
   input wire logic PORT_RELEASE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic pin_d_ff;
   logic [3:0] age_ff;
   logic [3:0] nxt_age;
   // Saturating age of the last rising pin edge, in processor cycles.
   assign nxt_age = (ASYNC_CLOCK_PIN_IN && !pin_d_ff) ? 4'h0 :
                    (age_ff == 4'hF) ? 4'hF : age_ff + 4'h1;
   always_ff @(posedge CLK) begin
      pin_d_ff <= ASYNC_CLOCK_PIN_IN;
      age_ff <= RST_N ? nxt_age : 4'hF;
   end
   sequence s_read(logic [3:0] a);
      REG_RD && REG_ADDR == a;
   endsequence
   sequence s_recent_edge;
      age_ff <= 4'h6;
   endsequence
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data not idle");
   a_unmapped_zero: assert property (REG_RD && REG_ADDR > ATC_OFS_GTC |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_flags_upper: assert property (s_read(ATC_OFS_FLAGS) |=> REG_RDATA[7:3] == 5'h00)
      else $error("flag upper bits not zero");
   a_status_top: assert property (s_read(ATC_OFS_ASTAT) |=> !REG_RDATA[7])
      else $error("status top bit set");
   a_irq_global: assert property (!$past(GLOBAL_IRQ_EN) |-> IRQ_REQ == 3'h0)
      else $error("interrupt without global enable");
   a_osc_deep: assert property ($past(DEEP_SLEEP) |-> !OSC_RUN)
      else $error("oscillator runs in deep sleep");
   a_osc_async: assert property (OSC_RUN |-> PORT_RELEASE)
      else $error("oscillator runs without async select");
   a_wake_drop: assert property (!SLEEP_ACTIVE |=> !WAKE_REQ)
      else $error("wake held while awake");
   a_wake_edge: assert property ($rose(WAKE_REQ) |-> $past(SLEEP_ACTIVE) ##0 s_recent_edge)
      else $error("wake not on a timer edge");
   a_cmp_on_edge: assert property (PORT_RELEASE && ($changed(COMPARE_A_OUT) ||
      $changed(COMPARE_B_OUT)) |-> s_recent_edge)
      else $error("compare output off the timer edge");
endmodule

//--- tb/atc_timer_async_tb.sv
// Purpose: Self-checking bench for the asynchronous timer controller.
// Assumes: Oscillator scaled to twenty processor cycles a period.
// Notes: Expectations come from the register map, never from the design.
`timescale 1ns/1ps
module atc_timer_async_tb;
   import atc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic gie = 1'b0;
   logic sleep = 1'b0;
   logic deep = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [2:0] vec_done = 3'h0;
   logic [7:0] reg_rdata;
   logic [2:0] irq;
   logic pin, wake, cmp_a, cmp_b, osc_run, port_rel;
   int err_total = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   atc_osc_model #(.HALF_NS(1000)) osc (.RUN(osc_run), .PIN(pin));
   atc_timer_async dut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ASYNC_CLOCK_PIN_IN(pin),
      .GLOBAL_IRQ_EN(gie), .VECTOR_DONE(vec_done), .SLEEP_ACTIVE(sleep), .DEEP_SLEEP(deep),
      .IRQ_REQ(irq), .WAKE_REQ(wake), .COMPARE_A_OUT(cmp_a), .COMPARE_B_OUT(cmp_b),
      .OSC_RUN(osc_run), .PORT_RELEASE(port_rel));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_raw(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_raw(a, d);
      chk(d, exp);
   endtask
   // Waits for rising pin edges, then lets the synchroniser settle.
   task automatic pin_edges(input int n);
      repeat (n) @(posedge pin);
      repeat (6) @(posedge clk);
   endtask
   task automatic poll(input logic [3:0] a, input logic [7:0] m);
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 3000 && (d & m) == 8'h00; i++) rd_raw(a, d);
      chk(d & m, m);
   endtask
   task automatic t_reset_map();
      for (int a = 0; a < 9; a++) rd(a[3:0], ATC_RST_BYTE);
      chk({6'h00, port_rel, osc_run}, 8'h00);
   endtask
   task automatic t_sync_rw();
      wr(ATC_OFS_CMPA, 8'h5A);
      rd(ATC_OFS_CMPA, 8'h5A);
      rd(ATC_OFS_ASTAT, 8'h00);
      for (int c = 7; c >= 0; c--) begin
         wr(ATC_OFS_CTLB, {5'h00, c[2:0]});
         rd(ATC_OFS_CTLB, {5'h00, c[2:0]});
      end
      wr(ATC_OFS_MASK, 8'hFF);
      rd(ATC_OFS_MASK, 8'h07);
      wr(ATC_OFS_MASK, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
   endtask
   task automatic t_async_hold();
      wr(ATC_OFS_ASTAT, 8'h20);
      rd(ATC_OFS_ASTAT, 8'h20);
      chk({6'h00, port_rel, osc_run}, 8'h03);
      @(negedge pin);
      wr(ATC_OFS_CMPA, 8'h11);
      rd(ATC_OFS_CMPA, 8'h11);
      rd(ATC_OFS_ASTAT, 8'h28);
      pin_edges(1);
      wr(ATC_OFS_CTLA, 8'h00);
      rd(ATC_OFS_ASTAT, 8'h2A);
      pin_edges(1);
      rd(ATC_OFS_ASTAT, 8'h22);
      pin_edges(1);
      rd(ATC_OFS_ASTAT, 8'h20);
      wr(ATC_OFS_COUNT, 8'h33);
      pin_edges(3);
      rd(ATC_OFS_COUNT, 8'h33);
      wr(ATC_OFS_FLAGS, 8'h07);
      rd(ATC_OFS_FLAGS, 8'h00);
   endtask
   task automatic t_flags();
      wr(ATC_OFS_CMPB, 8'h40);
      wr(ATC_OFS_COUNT, 8'h0F);
      wr(ATC_OFS_CTLB, 8'h01);
      poll(ATC_OFS_FLAGS, 8'h02);
      chk({7'h00, cmp_a}, 8'h01);
      wr(ATC_OFS_FLAGS, 8'h00);
      rd(ATC_OFS_FLAGS, 8'h02);
      wr(ATC_OFS_MASK, 8'h02);
      gie <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({5'h00, irq}, 8'h02);
      wr(ATC_OFS_FLAGS, 8'h02);
      rd(ATC_OFS_FLAGS, 8'h00);
      poll(ATC_OFS_FLAGS, 8'h04);
      vec_done <= 3'h4;
      @(posedge clk);
      vec_done <= 3'h0;
      rd(ATC_OFS_FLAGS, 8'h00);
   endtask
   task automatic t_prescaler();
      @(negedge pin);
      wr(ATC_OFS_GTC, 8'h02);
      rd(ATC_OFS_GTC, 8'h02);
      pin_edges(1);
      rd(ATC_OFS_GTC, 8'h00);
      wr(ATC_OFS_GTC, 8'h82);
      pin_edges(2);
      rd(ATC_OFS_GTC, 8'h82);
      wr(ATC_OFS_GTC, 8'h02);
      pin_edges(1);
      rd(ATC_OFS_GTC, 8'h00);
   endtask
   task automatic t_wake();
      wr(ATC_OFS_MASK, 8'h01);
      wr(ATC_OFS_FLAGS, 8'h07);
      rd(ATC_OFS_ASTAT, 8'h20);
      sleep <= 1'b1;
      for (int i = 0; i < 8000 && wake !== 1'b1; i++) @(posedge clk);
      chk({7'h00, wake}, 8'h01);
      sleep <= 1'b0;
      gie <= 1'b0;
      deep <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk({6'h00, wake, osc_run}, 8'h00);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      // The model oscillator is stable at once, so no settling wait is kept here.
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_map();
      t_sync_rw();
      t_async_hold();
      t_flags();
      t_prescaler();
      t_wake();
      close_out();
   end
   // The whole sequence needs well under forty thousand cycles.
   initial begin
      #(40000 * 100);
      err_total++;
      close_out();
   end
endmodule
bind atc_timer_async atc_timer_async_chk u_chk (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ASYNC_CLOCK_PIN_IN(ASYNC_CLOCK_PIN_IN),
   .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .SLEEP_ACTIVE(SLEEP_ACTIVE), .DEEP_SLEEP(DEEP_SLEEP),
   .IRQ_REQ(IRQ_REQ), .WAKE_REQ(WAKE_REQ), .COMPARE_A_OUT(COMPARE_A_OUT),
   .COMPARE_B_OUT(COMPARE_B_OUT), .OSC_RUN(OSC_RUN), .PORT_RELEASE(PORT_RELEASE));
